// ---- rtl/omc_override_ctrl.sv ----
// output override and maintenance control: maintenance mode, disarm, force,
// manual trip, reboot and health indication behind an Avalon-MM slave
// assumes all inputs synchronous to core_clk_i; contact drivers sit outside
//
// Implementation choices: the address map and the Avalon-MM slave port.

// Operation
// R1 - maintenance from panel, communication or input
// R2 - maintenance state kept in nonvolatile store
// R3 - manual activation only from panel
// R4 - refuse source change while activation asserted
// R5 - complementary active and inactive status outputs
// R6 - disarmed group contacts never switch
// R7 - timed disarm ends when timer expires
// R8 - permanent disarm holds until cancelled; the code also ends it when the group's disarm control bit is cleared
// R9 - zone and supervision outputs never disarmed
// R10 - disarm needs unlatched, no hold, control, command
// R11 - timed force ends when timer expires
// R12 - permanent force holds until cancelled
// R13 - group force beats single-contact force
// R14 - disarming dominates forcing
// R15 - force applies only undisarmed commanded contacts
// R16 - service command issues manual trip
// R17 - steady green only after boot, protection running
// R18 - reboot on operator service request
// R19 - flag measured rotation differing from setting
// R20 - separate timeout timer per group function
module omc_override_ctrl #(
    parameter int unsigned TICK_CYCLES = omc_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // register bus
    input wire omc_pkg::omc_avs_req_type avs_req_i,
    output logic [omc_pkg::DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // maintenance sources and storage
    input wire logic panel_maint_set_i,
    input wire logic panel_maint_clr_i,
    input wire logic maint_di_i,
    input wire logic nv_state_i,
    output logic nv_wr_o,
    output logic nv_data_o,
    output logic maint_active_o,
    output logic maint_inactive_o,
    // relay outputs
    input wire logic [omc_pkg::NC-1:0] prot_req_i,
    input wire logic [omc_pkg::NC-1:0] latched_i,
    input wire logic [omc_pkg::NC-1:0] hold_run_i,
    input wire logic zone_req_i,
    input wire logic supv_req_i,
    output logic [omc_pkg::NC-1:0] contact_o,
    output logic zone_o,
    output logic supv_o,
    // service and health
    input wire logic boot_done_i,
    input wire logic prot_run_i,
    input wire logic meas_rot_i,
    output logic trip_o,
    output logic reboot_o,
    output logic health_green_o,
    output logic rot_mismatch_o
);
    import omc_pkg::*;

    logic wait_q;
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] next_rdata;
    logic [1:0] src;
    logic man_flag;
    logic comm_flag;
    logic src_rej;
    logic man_rej;
    logic [NG-1:0] dis_ctrl;
    logic [NG-1:0] dis_perm;
    logic [NG-1:0] frc_perm;
    logic [NC+NG-1:0] frc_val;
    logic [DW-1:0] dis_tmo;
    logic [DW-1:0] frc_tmo;
    logic rot_cfg;
    omc_mstate_type mstate;
    omc_mstate_type next_mstate;
    logic [TCW-1:0] tick_cnt;
    logic tick;
    logic [NG-1:0] dis_on;
    logic [NG-1:0] frc_grp;
    logic [NC-1:0] sgl_on;
    logic [TW-1:0] dis_cnt [NG];
    logic [TW-1:0] frc_cnt [NG];
    wire [NG-1:0] next_dis_on;
    wire [NG-1:0] next_frc_grp;
    wire [NC-1:0] next_sgl;
    wire [NC-1:0] next_contact;
    wire [NC-1:0] dis_c;
    wire [TW-1:0] next_dis_cnt [NG];
    wire [TW-1:0] next_frc_cnt [NG];

    // bus: one wait cycle, then the request completes
    wire [AW-1:0] addr = avs_req_i.address;
    wire [DW-1:0] wd = avs_req_i.writedata;
    wire bus_req = avs_req_i.read | avs_req_i.write;
    wire wr_en = avs_req_i.write & ~wait_q;
    wire wr_msrc = wr_en & (addr == OFF_MSRC);
    wire wr_mcmd = wr_en & (addr == OFF_MCMD);
    wire wr_stat = wr_en & (addr == OFF_STAT);
    wire wr_dctl = wr_en & (addr == OFF_DCTL);
    wire wr_dcmd = wr_en & (addr == OFF_DCMD);
    wire wr_fcfg = wr_en & (addr == OFF_FCFG);
    wire wr_fcmd = wr_en & (addr == OFF_FCMD);
    wire wr_fval = wr_en & (addr == OFF_FVAL);
    wire wr_dtmo = wr_en & (addr == OFF_DTMO);
    wire wr_ftmo = wr_en & (addr == OFF_FTMO);
    wire wr_serv = wr_en & (addr == OFF_SERV);
    wire wr_rot = wr_en & (addr == OFF_ROT);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= ~(bus_req & wait_q);
            if (bus_req && wait_q) begin
                rdata_q <= next_rdata;
            end
        end
    end
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

    always_comb begin
        next_rdata = '0;
        if (addr == OFF_MSRC) begin
            next_rdata[1:0] = src;
        end else if (addr == OFF_STAT) begin
            next_rdata[5:0] = {health_green_o, rot_mismatch_o, mstate == MS_ON, man_rej,
                               src_rej, maint_active_o};
        end else if (addr == OFF_DCTL) begin
            next_rdata[2*NG-1:0] = {dis_perm, dis_ctrl};
        end else if (addr == OFF_FCFG) begin
            next_rdata[NG-1:0] = frc_perm;
        end else if (addr == OFF_FVAL) begin
            next_rdata[NC+NG-1:0] = frc_val;
        end else if (addr == OFF_DTMO) begin
            next_rdata = dis_tmo;
        end else if (addr == OFF_FTMO) begin
            next_rdata = frc_tmo;
        end else if (addr == OFF_ROT) begin
            next_rdata[0] = rot_cfg;
        end else if (addr == OFF_OUTS) begin
            next_rdata[3*NC+NG-1:0] = {sgl_on, frc_grp, dis_c, contact_o};
        end
    end

    // maintenance activation; the bus stands for the remote tool
    wire src_act = (src == SRC_DI) ? maint_di_i :
                   (src == SRC_COMM) ? comm_flag : man_flag; // R1
    wire src_try = wr_msrc & (wd[1:0] != SRC_BAD);
    wire src_refuse = wr_msrc & src_act; // R4
    wire man_from_bus = wr_mcmd & wd[MC_MAN_REQ]; // R3
    wire restoring = (mstate == MS_INIT);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src <= SRC_RST;
            man_flag <= 1'b0;
            comm_flag <= 1'b0;
            src_rej <= 1'b0;
            man_rej <= 1'b0;
        end else begin
            if (src_try && !src_act) begin
                src <= wd[1:0]; // R4
            end
            // stored state reloads both latched sources after power-up
            if (restoring) begin
                man_flag <= nv_state_i; // R2
                comm_flag <= nv_state_i;
            end else begin
                man_flag <= panel_maint_set_i | (man_flag & ~panel_maint_clr_i); // R3
                comm_flag <= (wr_mcmd & wd[MC_COMM_SET]) |
                             (comm_flag & ~(wr_mcmd & wd[MC_COMM_CLR])); // R1
            end
            // sticky flags: a new event wins over a write-one clear
            src_rej <= src_refuse | (src_rej & ~(wr_stat & wd[ST_SRC_REJ]));
            man_rej <= man_from_bus | (man_rej & ~(wr_stat & wd[ST_MAN_REJ]));
        end
    end

    always_comb begin
        next_mstate = mstate;
        case (mstate)
            MS_INIT: next_mstate = nv_state_i ? MS_ON : MS_OFF; // R2
            MS_OFF: next_mstate = src_act ? MS_ON : MS_OFF;
            MS_ON: next_mstate = src_act ? MS_ON : MS_OFF;
            default: next_mstate = MS_INIT;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mstate <= MS_INIT;
            maint_active_o <= 1'b0;
            maint_inactive_o <= 1'b0;
            nv_wr_o <= 1'b0;
            nv_data_o <= 1'b0;
        end else begin
            mstate <= next_mstate;
            maint_active_o <= (next_mstate == MS_ON); // R5
            maint_inactive_o <= (next_mstate == MS_OFF); // R5
            // store only real changes, never the restore itself
            nv_wr_o <= !restoring && (next_mstate != mstate); // R2
            nv_data_o <= (next_mstate == MS_ON);
        end
    end

    // configuration registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dis_ctrl <= '0;
            dis_perm <= '0;
            frc_perm <= '0;
            frc_val <= '0;
            dis_tmo <= TMO_RST;
            frc_tmo <= TMO_RST;
            rot_cfg <= 1'b0;
        end else begin
            if (wr_dctl) begin
                {dis_perm, dis_ctrl} <= wd[2*NG-1:0];
            end
            if (wr_fcfg) begin
                frc_perm <= wd[NG-1:0];
            end
            if (wr_fval) begin
                frc_val <= wd[NC+NG-1:0];
            end
            if (wr_dtmo) begin
                dis_tmo <= wd;
            end
            if (wr_ftmo) begin
                frc_tmo <= wd;
            end
            if (wr_rot) begin
                rot_cfg <= wd[0];
            end
        end
    end

    // millisecond step for the timeouts
    assign tick = (tick_cnt == TCW'(TICK_CYCLES - 1));
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
        end
    end

    // disarm and force per output card group
    for (genvar g = 0; g < NG; g++) begin : grp
        wire dapply = wr_dcmd & wd[g] & dis_ctrl[g];
        wire dcancel = wr_dcmd & wd[NG+g];
        wire dexp = dis_on[g] & ~dis_perm[g] & (dis_cnt[g] == '0); // R7
        wire fgapply = wr_fcmd & wd[NC+g];
        wire fsapply = wr_fcmd & (|wd[g*CPG +: CPG]);
        wire fcancel = wr_fcmd & wd[NC+NG+g];
        wire factive = frc_grp[g] | (|sgl_on[g*CPG +: CPG]);
        wire fexp = factive & ~frc_perm[g] & (frc_cnt[g] == '0); // R11
        // dropping the control also ends a disarm; permanent waits for cancel
        assign next_dis_on[g] = dis_ctrl[g] & ~dcancel &
                                (dapply | (dis_on[g] & ~dexp)); // R8
        assign next_dis_cnt[g] = dapply ? dis_tmo[g*TW +: TW] :
                                 (tick && dis_cnt[g] != '0) ? dis_cnt[g] - 1'b1 :
                                 dis_cnt[g]; // R20
        assign next_frc_grp[g] = ~fcancel & (fgapply | (frc_grp[g] & ~fexp)); // R12
        assign next_frc_cnt[g] = (fgapply | fsapply) ? frc_tmo[g*TW +: TW] :
                                 (tick && frc_cnt[g] != '0) ? frc_cnt[g] - 1'b1 :
                                 frc_cnt[g]; // R20
        for (genvar c = 0; c < CPG; c++) begin : ct
            localparam int I = g * CPG + c;
            assign dis_c[I] = dis_on[g] & ~latched_i[I] & ~hold_run_i[I]; // R10
            // a single force aimed at a disarmed contact is dropped
            assign next_sgl[I] = ~fcancel &
                                 ((wr_fcmd & wd[I] & ~dis_c[I]) | (sgl_on[I] & ~fexp)); // R14
            assign next_contact[I] = dis_c[I] ? contact_o[I] : // R6
                                     frc_grp[g] ? frc_val[NC+g] : // R13
                                     sgl_on[I] ? frc_val[I] : prot_req_i[I]; // R15
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dis_on <= '0;
            frc_grp <= '0;
            sgl_on <= '0;
            dis_cnt <= '{default: '0};
            frc_cnt <= '{default: '0};
            contact_o <= '0;
            zone_o <= 1'b0;
            supv_o <= 1'b0;
        end else begin
            dis_on <= next_dis_on;
            frc_grp <= next_frc_grp;
            sgl_on <= next_sgl;
            dis_cnt <= next_dis_cnt;
            frc_cnt <= next_frc_cnt;
            contact_o <= next_contact;
            zone_o <= zone_req_i; // R9
            supv_o <= supv_req_i; // R9
        end
    end

    // service actions and indication
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trip_o <= 1'b0;
            reboot_o <= 1'b0;
            health_green_o <= 1'b0;
            rot_mismatch_o <= 1'b0;
        end else begin
            // held until the next millisecond step so the breaker sees it
            trip_o <= (wr_serv & wd[SV_TRIP]) | (trip_o & ~tick); // R16
            reboot_o <= wr_serv & wd[SV_REBOOT]; // R18
            health_green_o <= boot_done_i & prot_run_i; // R17
            rot_mismatch_o <= meas_rot_i ^ rot_cfg; // R19
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_compl;
        !restoring |-> (maint_active_o != maint_inactive_o);
    endproperty
    a_compl: assert property (p_compl) else $error("maintenance status not complementary"); // R5
    property p_restore;
        restoring |=> ##1 (maint_active_o == $past(nv_state_i, 2));
    endproperty
    a_restore: assert property (p_restore) else $error("stored state not restored"); // R2
    property p_bus_manual;
        man_from_bus && src == SRC_MANUAL && !man_flag && !panel_maint_set_i && !restoring
            |=> ##1 !maint_active_o && man_rej;
    endproperty
    a_bus_manual: assert property (p_bus_manual) else $error("remote manual activation taken"); // R3
    property p_src_lock;
        wr_msrc && src_act |=> $stable(src) && src_rej;
    endproperty
    a_src_lock: assert property (p_src_lock) else $error("source changed while active"); // R4
    property p_dis_hold;
        dis_c[0] |=> $stable(contact_o[0]);
    endproperty
    a_dis_hold: assert property (p_dis_hold) else $error("disarmed contact switched"); // R6
    property p_dis_tmo;
        dis_on[0] && !dis_perm[0] && dis_cnt[0] == '0 && !(wr_dcmd && wd[0]) |=> !dis_on[0];
    endproperty
    a_dis_tmo: assert property (p_dis_tmo) else $error("timed disarm outlived timer"); // R7
    // checked one cycle at a time: a cancel in the next cycle may legally end it
    property p_dis_perm;
        dis_on[0] && dis_perm[0] && dis_ctrl[0] && !wr_dctl && !(wr_dcmd && wd[NG])
            |=> dis_on[0];
    endproperty
    a_dis_perm: assert property (p_dis_perm) else $error("permanent disarm dropped"); // R8
    property p_zone;
        ##1 1 |-> zone_o == $past(zone_req_i) && supv_o == $past(supv_req_i);
    endproperty
    a_zone: assert property (p_zone) else $error("excluded output not following"); // R9
    property p_dis_cond;
        (latched_i[0] || hold_run_i[0] || !dis_on[0]) |-> !dis_c[0];
    endproperty
    a_dis_cond: assert property (p_dis_cond) else $error("contact disarmed illegally"); // R10
    property p_grp_force;
        frc_grp[0] && !dis_c[0] |=> contact_o[0] == $past(frc_val[NC]);
    endproperty
    a_grp_force: assert property (p_grp_force) else $error("group force not dominant"); // R13
    property p_frc_tmo;
        frc_grp[1] && !frc_perm[1] && frc_cnt[1] == '0 && !wr_fcmd |=> !frc_grp[1];
    endproperty
    a_frc_tmo: assert property (p_frc_tmo) else $error("timed force outlived timer"); // R11
    property p_trip;
        wr_serv && wd[SV_TRIP] |=> trip_o;
    endproperty
    a_trip: assert property (p_trip) else $error("manual trip not issued"); // R16
    property p_health;
        !(boot_done_i && prot_run_i) |=> !health_green_o;
    endproperty
    a_health: assert property (p_health) else $error("green without running protection"); // R17
    property p_reboot;
        wr_serv && wd[SV_REBOOT] |=> reboot_o ##1 !reboot_o;
    endproperty
    a_reboot: assert property (p_reboot) else $error("reboot pulse wrong"); // R18
    property p_tmo_load;
        wr_dcmd && wd[1] && dis_ctrl[1] |=> dis_cnt[1] == $past(dis_tmo[2*TW-1:TW]);
    endproperty
    a_tmo_load: assert property (p_tmo_load) else $error("disarm timer not loaded"); // R20
    c_maint_on: cover property (mstate == MS_OFF ##1 mstate == MS_ON);
    c_disarm: cover property (dis_c[0] && prot_req_i[0] != contact_o[0]);
    c_force: cover property (sgl_on[1] && !frc_grp[0] ##1 contact_o[1] == frc_val[1]);
    c_expire: cover property (dis_on[0] ##1 !dis_on[0]);
endmodule

// ---- rtl/omc_pkg.sv ----
// package for the output override and maintenance control block
// assumes a 125 MHz core clock and an Avalon-MM master with waitrequest
package omc_pkg;
    // structure
    localparam int NG = 2;
    localparam int CPG = 4;
    localparam int NC = NG * CPG;
    localparam int AW = 6;
    localparam int DW = 32;
    localparam int TW = 16;
    // register byte offsets
    localparam logic [AW-1:0] OFF_MSRC = 6'h00;
    localparam logic [AW-1:0] OFF_MCMD = 6'h04;
    localparam logic [AW-1:0] OFF_STAT = 6'h08;
    localparam logic [AW-1:0] OFF_DCTL = 6'h0C;
    localparam logic [AW-1:0] OFF_DCMD = 6'h10;
    localparam logic [AW-1:0] OFF_FCFG = 6'h14;
    localparam logic [AW-1:0] OFF_FCMD = 6'h18;
    localparam logic [AW-1:0] OFF_FVAL = 6'h1C;
    localparam logic [AW-1:0] OFF_DTMO = 6'h20;
    localparam logic [AW-1:0] OFF_FTMO = 6'h24;
    localparam logic [AW-1:0] OFF_SERV = 6'h28;
    localparam logic [AW-1:0] OFF_ROT = 6'h2C;
    localparam logic [AW-1:0] OFF_OUTS = 6'h30;
    // field positions
    localparam int MC_COMM_SET = 0;
    localparam int MC_COMM_CLR = 1;
    localparam int MC_MAN_REQ = 2;
    localparam int SV_TRIP = 0;
    localparam int SV_REBOOT = 1;
    localparam int ST_SRC_REJ = 1;
    localparam int ST_MAN_REJ = 2;
    // activation source codes and reset values
    localparam logic [1:0] SRC_MANUAL = 2'h0;
    localparam logic [1:0] SRC_COMM = 2'h1;
    localparam logic [1:0] SRC_DI = 2'h2;
    localparam logic [1:0] SRC_BAD = 2'h3;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [DW-1:0] TMO_RST = 32'h03E8_03E8;
    // timing: timeouts count in steps of one millisecond
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int TCW = 17;

    typedef enum logic [2:0] {
        MS_INIT = 3'b001,
        MS_OFF = 3'b010,
        MS_ON = 3'b100
    } omc_mstate_type;

    typedef struct packed {
        logic [AW-1:0] address;
        logic read;
        logic write;
        logic [DW-1:0] writedata;
    } omc_avs_req_type;
endpackage

// ---- verification/omc_panel_model.sv ----
// operator panel keys, maintenance digital input and nonvolatile store model
// assumes the bench changes key and input levels just after rising edges
module omc_panel_model (
    // clock
    input wire logic core_clk_i,
    // operator and field side
    input wire logic press_set_i,
    input wire logic press_clr_i,
    input wire logic di_level_i,
    // towards the block
    input wire logic nv_wr_i,
    input wire logic nv_data_i,
    output logic panel_maint_set_o,
    output logic panel_maint_clr_o,
    output logic maint_di_o,
    output logic nv_state_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic set_q = 1'b0;
    logic clr_q = 1'b0;
    // the store has no reset: it must outlive a reset of the block
    initial nv_state_o = 1'b0;
    always @(posedge core_clk_i) begin
        set_q <= press_set_i;
        clr_q <= press_clr_i;
        if (nv_wr_i) nv_state_o <= nv_data_i;
    end
    // a held key reaches the block as one pulse, like a debounced panel key
    assign panel_maint_set_o = press_set_i & ~set_q;
    assign panel_maint_clr_o = press_clr_i & ~clr_q;
    assign maint_di_o = di_level_i;
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the output override and maintenance control block
// assumes the panel model above and a short millisecond tick of 8 cycles
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import omc_pkg::*;
    localparam int unsigned TK = 8;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    omc_avs_req_type req = '0;
    logic [DW-1:0] rdata;
    logic [DW-1:0] q;
    logic wait_req;
    logic p_set = 1'b0;
    logic p_clr = 1'b0;
    logic di = 1'b0;
    logic pm_set, pm_clr, m_di, nv_st, nv_wr, nv_data, m_act, m_inact;
    logic [NC-1:0] prot = '0;
    logic [NC-1:0] latch = '0;
    logic [NC-1:0] hold = '0;
    logic [NC-1:0] contacts;
    logic zone_req = 1'b0;
    logic supv_req = 1'b0;
    logic boot = 1'b0;
    logic prun = 1'b0;
    logic mrot = 1'b0;
    logic zone, supv, trip, reboot, green, rot_mm;
    int n_fail = 0;
    int check_count = 0;
    int trip_cyc = 0;
    int reboot_cnt = 0;

    initial forever #4 core_clk_i = ~core_clk_i;

    omc_panel_model u_panel (.core_clk_i(core_clk_i), .press_set_i(p_set), .press_clr_i(p_clr),
        .di_level_i(di), .nv_wr_i(nv_wr), .nv_data_i(nv_data), .panel_maint_set_o(pm_set),
        .panel_maint_clr_o(pm_clr), .maint_di_o(m_di), .nv_state_o(nv_st));

    omc_override_ctrl #(.TICK_CYCLES(TK)) u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
        .panel_maint_set_i(pm_set), .panel_maint_clr_i(pm_clr), .maint_di_i(m_di),
        .nv_state_i(nv_st), .nv_wr_o(nv_wr), .nv_data_o(nv_data), .maint_active_o(m_act),
        .maint_inactive_o(m_inact), .prot_req_i(prot), .latched_i(latch), .hold_run_i(hold),
        .zone_req_i(zone_req), .supv_req_i(supv_req), .contact_o(contacts), .zone_o(zone),
        .supv_o(supv), .boot_done_i(boot), .prot_run_i(prun), .meas_rot_i(mrot),
        .trip_o(trip), .reboot_o(reboot), .health_green_o(green), .rot_mismatch_o(rot_mm));

    always @(posedge core_clk_i) begin
        if (trip === 1'b1) trip_cyc++;
        if (reboot === 1'b1) reboot_cnt++;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // request held until waitrequest is sampled low; only the watchdog ends a hung wait
    task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge core_clk_i);
        req.address <= a;
        req.write <= wr;
        req.read <= ~wr;
        req.writedata <= d;
        do begin
            @(posedge core_clk_i);
        end while (wait_req !== 1'b0);
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_reg(input logic [AW-1:0] a);
        bus(1'b0, a, '0);
    endtask

    task automatic press(input logic on);
        if (on) p_set <= 1'b1;
        else p_clr <= 1'b1;
        cyc(2);
        p_set <= 1'b0;
        p_clr <= 1'b0;
        cyc(4);
    endtask

    initial begin
        #100000;
        n_fail++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        complete_run();
    end

    initial begin
        cyc(6);
        resetn_i <= 1'b1;
        cyc(3);
        check("maint outputs", 32'({m_act, m_inact}), 32'h1);
        wr_reg(OFF_MCMD, 32'h4);
        rd_reg(OFF_STAT);
        check("manual from bus", q & 32'h5, 32'h4);
        wr_reg(OFF_STAT, 32'h6);
        press(1'b1);
        check("panel on", 32'({m_act, m_inact, nv_st}), 32'h5);
        wr_reg(OFF_MSRC, 32'(SRC_COMM));
        rd_reg(OFF_MSRC);
        check("source held", q & 32'h3, 32'(SRC_MANUAL));
        rd_reg(OFF_STAT);
        check("source refused", q & 32'h3, 32'h3);
        wr_reg(OFF_STAT, 32'h6);
        press(1'b0);
        check("panel off", 32'({m_act, m_inact, nv_st}), 32'h2);
        wr_reg(OFF_MSRC, 32'(SRC_DI));
        di <= 1'b1;
        cyc(4);
        check("input on", 32'(m_act), 32'h1);
        wr_reg(OFF_MSRC, 32'(SRC_COMM));
        rd_reg(OFF_MSRC);
        check("source held on input", q & 32'h3, 32'(SRC_DI));
        di <= 1'b0;
        cyc(4);
        wr_reg(OFF_MSRC, 32'(SRC_COMM));
        wr_reg(OFF_MCMD, 32'h1);
        cyc(4);
        check("comm on", 32'(m_act), 32'h1);
        resetn_i <= 1'b0;
        cyc(2);
        resetn_i <= 1'b1;
        cyc(4);
        check("restored on", 32'({m_act, m_inact}), 32'h2);
        press(1'b0);
        check("restored off", 32'({m_act, m_inact}), 32'h1);
        // disarm: control missing, then timed with one latched and one held contact
        wr_reg(OFF_DTMO, 32'h0004_0004);
        wr_reg(OFF_DCMD, 32'h1);
        prot <= 8'hFF;
        cyc(3);
        check("no control", 32'(contacts), 32'hFF);
        prot <= 8'h00;
        latch <= 8'h01;
        hold <= 8'h02;
        zone_req <= 1'b1;
        supv_req <= 1'b1;
        wr_reg(OFF_DCTL, 32'h1);
        wr_reg(OFF_DCMD, 32'h1);
        prot <= 8'hFF;
        cyc(3);
        check("timed disarm", 32'(contacts), 32'hF3);
        check("zone supv", 32'({zone, supv}), 32'h3);
        cyc(60);
        check("disarm expired", 32'(contacts), 32'hFF);
        latch <= 8'h00;
        hold <= 8'h00;
        prot <= 8'h00;
        wr_reg(OFF_DCTL, 32'h5);
        wr_reg(OFF_DCMD, 32'h1);
        prot <= 8'hFF;
        cyc(60);
        check("permanent disarm", 32'(contacts), 32'hF0);
        wr_reg(OFF_FVAL, 32'h100);
        wr_reg(OFF_FCMD, 32'h100);
        cyc(3);
        check("force on disarmed", 32'(contacts), 32'hF0);
        rd_reg(OFF_OUTS);
        check("disarmed mask", q & 32'hFF00, 32'h0F00);
        wr_reg(OFF_DCMD, 32'h4);
        wr_reg(OFF_FCMD, 32'hC00);
        cyc(3);
        check("disarm cancel", 32'(contacts), 32'hFF);
        wr_reg(OFF_DCTL, 32'h2);
        wr_reg(OFF_DCMD, 32'h2);
        prot <= 8'h00;
        cyc(3);
        check("group1 disarm", 32'(contacts), 32'hF0);
        cyc(60);
        check("group1 disarm expired", 32'(contacts), 32'h00);
        // group timers differ so each group expires on its own
        prot <= 8'h00;
        wr_reg(OFF_FTMO, 32'h0014_0004);
        wr_reg(OFF_FVAL, 32'h22);
        wr_reg(OFF_FCMD, 32'h222);
        cyc(3);
        check("group over single", 32'(contacts), 32'h02);
        prot <= 8'hFF;
        cyc(60);
        check("group0 expired", 32'(contacts), 32'h0F);
        cyc(150);
        check("group1 expired", 32'(contacts), 32'hFF);
        wr_reg(OFF_FCFG, 32'h1);
        wr_reg(OFF_FVAL, 32'h0);
        wr_reg(OFF_FCMD, 32'h100);
        cyc(60);
        check("permanent force", 32'(contacts), 32'hF0);
        wr_reg(OFF_FCMD, 32'h400);
        cyc(3);
        check("force cancel", 32'(contacts), 32'hFF);
        wr_reg(OFF_SERV, 32'h1);
        cyc(12);
        check("trip length", 32'(trip_cyc >= 1 && trip_cyc <= TK), 32'h1);
        wr_reg(OFF_SERV, 32'h2);
        cyc(3);
        check("reboot pulses", 32'(reboot_cnt), 32'h1);
        boot <= 1'b1;
        cyc(3);
        check("green before run", 32'(green), 32'h0);
        prun <= 1'b1;
        cyc(3);
        check("green running", 32'(green), 32'h1);
        wr_reg(OFF_ROT, 32'h1);
        cyc(3);
        check("rotation differs", 32'(rot_mm), 32'h1);
        mrot <= 1'b1;
        cyc(3);
        check("rotation same", 32'(rot_mm), 32'h0);
        wr_reg(6'h3C, 32'hFFFF_FFFF);
        rd_reg(6'h3C);
        check("unmapped", q, 32'h0);
        rd_reg(OFF_FTMO);
        check("timeout readback", q, 32'h0014_0004);
        complete_run();
    end
endmodule
